//--- hdl/terminal_block_supervisor.sv
// Terminal block supervisor: configuration, sign-of-life, supply and temperature
// Function
// - A block takes at most eight modules, one per slot; more is an invalid setup.
// - Per block at most 2 16-input, 2 16-output, 4 8-output, 8 analog in, 4 fast analog in, 4 analog out.
// - A block never holds more than four analog output and four analog input modules.
// - Over all blocks at most 32 digital in, 32 digital out, 8 analog in and 8 analog out.
// - Supply undervoltage disables all outputs and turns the green indicator off.
// - Overtemperature sends a status to the host and leaves the outputs enabled.
// - A missing host sign of life disables all outputs and lights the red indicator.
// - An expired microcontroller watchdog disables all outputs and lights the red indicator.
// - An invalid combination disables outputs, lights red and yellow, and reports to the host.
// - Host, controller or power faults assert the safe disable that zeroes every output.
// - The 16-input module lights one indicator per input while that input is one, three clock cycles behind it.
`timescale 1ns/1ps
`default_nettype none
module terminal_block_supervisor
   import tb_supervisor_pkg::*;
#(
   parameter int HOST_TIMEOUT = HOST_TIMEOUT_CYCLES,
   parameter int MCU_TIMEOUT = MCU_TIMEOUT_CYCLES
)
(
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic RESET,
   // Slot population, one type code per slot
   input wire logic [SLOT_COUNT*TYPE_WIDTH-1:0] SLOT_TYPES,
   // Channel counts already used by other blocks of the controller
   input wire logic [7:0] OTHER_DIN,
   input wire logic [7:0] OTHER_DOUT,
   input wire logic [7:0] OTHER_AIN,
   input wire logic [7:0] OTHER_AOUT,
   // Monitors and sign-of-life inputs from pins
   input wire logic UNDERVOLTAGE,
   input wire logic OVERTEMP,
   input wire logic HOST_BEAT,
   input wire logic MCU_BEAT,
   // Digital input module state
   input wire logic [15:0] DIN16_LEVELS,
   // Safe disable and indicators
   output logic OUTPUT_SAFE_DISABLE,
   output logic LED_GREEN,
   output logic LED_RED,
   output logic LED_YELLOW,
   output logic [15:0] DIN16_LEDS,
   // Status to host
   output logic STATUS_OVERTEMP,
   output logic STATUS_CONFIG_FAULT,
   output logic STATUS_HOST_LOST,
   output logic STATUS_MCU_LOST
);

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [3:0] sync_a;
   logic [3:0] sync_b;
   logic [15:0] din_a;
   logic [15:0] din_b;
   logic [SLOT_COUNT*TYPE_WIDTH-1:0] slot_a;
   logic [SLOT_COUNT*TYPE_WIDTH-1:0] slot_b;

   always_ff @(posedge CLK_SYS)
   begin
      if (RESET)
      begin
         sync_a <= 4'h0;
         sync_b <= 4'h0;
         din_a <= 16'h0000;
         din_b <= 16'h0000;
         slot_a <= '0;
         slot_b <= '0;
      end
      else
      begin
         sync_a <= {MCU_BEAT, HOST_BEAT, OVERTEMP, UNDERVOLTAGE};
         sync_b <= sync_a;
         din_a <= DIN16_LEVELS;
         din_b <= din_a;
         slot_a <= SLOT_TYPES;
         slot_b <= slot_a;
      end
   end

   logic undervoltage;
   logic overtemp;
   logic host_beat;
   logic mcu_beat;

   assign undervoltage = sync_b[0];
   assign overtemp = sync_b[1];
   assign host_beat = sync_b[2];
   assign mcu_beat = sync_b[3];

   // ----------------------------------------
   // Fault sources
   // ----------------------------------------
   logic host_lost;
   logic mcu_lost;
   logic block_invalid;
   logic system_invalid;
   logic config_fault;

   life_monitor #(
      .TIMEOUT(HOST_TIMEOUT)
   ) host_watch (
      .clk(CLK_SYS),
      .reset(RESET),
      .beat(host_beat),
      .expired(host_lost)
   );

   life_monitor #(
      .TIMEOUT(MCU_TIMEOUT)
   ) mcu_watch (
      .clk(CLK_SYS),
      .reset(RESET),
      .beat(mcu_beat),
      .expired(mcu_lost)
   );

   config_checker config_u (
      .slot_types(slot_b),
      .other_din(OTHER_DIN),
      .other_dout(OTHER_DOUT),
      .other_ain(OTHER_AIN),
      .other_aout(OTHER_AOUT),
      .block_invalid(block_invalid),
      .system_invalid(system_invalid)
   );

   assign config_fault = block_invalid || system_invalid;

   // ----------------------------------------
   // Run state
   // ----------------------------------------
   // Outputs stay off after reset until the first clean evaluation
   run_state_type state;
   run_state_type next_state;
   logic any_fault;

   // Overtemperature is left out on purpose: it only reports
   assign any_fault = undervoltage || host_lost || mcu_lost || config_fault;

   always_comb
   begin
      next_state = state;
      unique case (state)
         RUN_START:
            next_state = any_fault ? RUN_FAULT : RUN_OK;
         RUN_OK:
            if (any_fault)
               next_state = RUN_FAULT;
         RUN_FAULT:
            if (!any_fault)
               next_state = RUN_OK;
         default:
            next_state = RUN_START;
      endcase
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (RESET)
         state <= RUN_START;
      else
         state <= next_state;
   end

   // ----------------------------------------
   // Output registers
   // ----------------------------------------
   logic next_disable;

   assign next_disable = (next_state != RUN_OK);

   always_ff @(posedge CLK_SYS)
   begin
      if (RESET)
      begin
         OUTPUT_SAFE_DISABLE <= 1'b1;
         LED_GREEN <= 1'b0;
         LED_RED <= 1'b0;
         LED_YELLOW <= 1'b0;
         DIN16_LEDS <= 16'h0000;
         STATUS_OVERTEMP <= 1'b0;
         STATUS_CONFIG_FAULT <= 1'b0;
         STATUS_HOST_LOST <= 1'b0;
         STATUS_MCU_LOST <= 1'b0;
      end
      else
      begin
         OUTPUT_SAFE_DISABLE <= next_disable;
         LED_GREEN <= !undervoltage;
         LED_RED <= host_lost || mcu_lost || config_fault;
         LED_YELLOW <= config_fault;
         DIN16_LEDS <= din_b;
         STATUS_OVERTEMP <= overtemp;
         STATUS_CONFIG_FAULT <= config_fault;
         STATUS_HOST_LOST <= host_lost;
         STATUS_MCU_LOST <= mcu_lost;
      end
   end

endmodule
`default_nettype wire

//--- hdl/tb_supervisor_pkg.sv
// Constants and types shared by the terminal block supervisor design
package tb_supervisor_pkg;

   // ----------------------------------------
   // Slots and module types
   // ----------------------------------------
   localparam int SLOT_COUNT = 8;
   localparam int TYPE_WIDTH = 3;
   localparam logic [2:0] TYPE_EMPTY = 3'h0;
   localparam logic [2:0] TYPE_DIN16 = 3'h1;
   localparam logic [2:0] TYPE_DOUT16 = 3'h2;
   localparam logic [2:0] TYPE_DOUT8 = 3'h3;
   localparam logic [2:0] TYPE_AIN = 3'h4;
   localparam logic [2:0] TYPE_AIN_FAST = 3'h5;
   localparam logic [2:0] TYPE_AOUT = 3'h6;

   // ----------------------------------------
   // Per block limits
   // ----------------------------------------
   localparam logic [3:0] MAX_MODULES = 4'h8;
   localparam logic [3:0] MAX_DIN16 = 4'h2;
   localparam logic [3:0] MAX_DOUT16 = 4'h2;
   localparam logic [3:0] MAX_DOUT8 = 4'h4;
   localparam logic [3:0] MAX_AIN = 4'h8;
   localparam logic [3:0] MAX_AIN_FAST = 4'h4;
   localparam logic [3:0] MAX_AOUT = 4'h4;
   localparam logic [3:0] MAX_ANALOG_IN_MIX = 4'h4;
   localparam logic [3:0] MAX_ANALOG_OUT_MIX = 4'h4;

   // ----------------------------------------
   // Controller-wide limits and channel counts per module type
   // ----------------------------------------
   localparam logic [7:0] MAX_SYS_DIN = 8'h20;
   localparam logic [7:0] MAX_SYS_DOUT = 8'h20;
   localparam logic [7:0] MAX_SYS_AIN = 8'h08;
   localparam logic [7:0] MAX_SYS_AOUT = 8'h08;
   localparam logic [7:0] DIN16_CHANNELS = 8'h10;
   localparam logic [7:0] DOUT16_CHANNELS = 8'h10;
   localparam logic [7:0] DOUT8_CHANNELS = 8'h08;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_MHZ = 50;
   localparam int HOST_TIMEOUT_US = 10000;
   localparam int MCU_TIMEOUT_US = 10000;
   localparam int HOST_TIMEOUT_CYCLES = HOST_TIMEOUT_US * CLK_MHZ;
   localparam int MCU_TIMEOUT_CYCLES = MCU_TIMEOUT_US * CLK_MHZ;
   localparam int TIMER_WIDTH = 24;

   typedef enum logic [1:0] {
      RUN_START,
      RUN_OK,
      RUN_FAULT
   } run_state_type;

endpackage

//--- hdl/life_monitor.sv
// Sign-of-life watchdog: a toggle on the beat input restarts the timer
`timescale 1ns/1ps
`default_nettype none
module life_monitor
   import tb_supervisor_pkg::*;
#(
   parameter int TIMEOUT = 1000
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic beat,
   output logic expired
);

   logic [TIMER_WIDTH-1:0] count;
   logic beat_last;
   logic beat_seen;
   logic at_limit;

   // Either edge counts; a stuck level in any state is a lost beat
   assign beat_seen = beat ^ beat_last;
   assign at_limit = (count >= TIMER_WIDTH'(TIMEOUT - 1));

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         count <= '0;
         beat_last <= 1'b0;
         expired <= 1'b0;
      end
      else
      begin
         beat_last <= beat;
         if (beat_seen)
         begin
            count <= '0;
            expired <= 1'b0;
         end
         else if (at_limit)
            expired <= 1'b1;
         else
            count <= count + 1'b1;
      end
   end

endmodule
`default_nettype wire

//--- hdl/config_checker.sv
// Plugged module combination check against slot and type limits
`timescale 1ns/1ps
`default_nettype none
module config_checker
   import tb_supervisor_pkg::*;
(
   input wire logic [SLOT_COUNT*TYPE_WIDTH-1:0] slot_types,
   input wire logic [7:0] other_din,
   input wire logic [7:0] other_dout,
   input wire logic [7:0] other_ain,
   input wire logic [7:0] other_aout,
   output logic block_invalid,
   output logic system_invalid
);

   logic [3:0] n_used;
   logic [3:0] n_din16;
   logic [3:0] n_dout16;
   logic [3:0] n_dout8;
   logic [3:0] n_ain;
   logic [3:0] n_ain_fast;
   logic [3:0] n_aout;
   // One bit wider than the inputs so a large count from other blocks cannot wrap
   logic [8:0] sys_din;
   logic [8:0] sys_dout;
   logic [8:0] sys_ain;
   logic [8:0] sys_aout;
   logic bad_type;

   always_comb
   begin
      logic [2:0] t;
      t = TYPE_EMPTY;
      n_used = '0;
      n_din16 = '0;
      n_dout16 = '0;
      n_dout8 = '0;
      n_ain = '0;
      n_ain_fast = '0;
      n_aout = '0;
      bad_type = 1'b0;
      for (int i = 0; i < SLOT_COUNT; i++)
      begin
         t = slot_types[i*TYPE_WIDTH +: TYPE_WIDTH];
         if (t != TYPE_EMPTY)
            n_used = n_used + 4'h1;
         if (t == TYPE_DIN16)
            n_din16 = n_din16 + 4'h1;
         if (t == TYPE_DOUT16)
            n_dout16 = n_dout16 + 4'h1;
         if (t == TYPE_DOUT8)
            n_dout8 = n_dout8 + 4'h1;
         if (t == TYPE_AIN)
            n_ain = n_ain + 4'h1;
         if (t == TYPE_AIN_FAST)
            n_ain_fast = n_ain_fast + 4'h1;
         if (t == TYPE_AOUT)
            n_aout = n_aout + 4'h1;
         if (t > TYPE_AOUT)
            bad_type = 1'b1;
      end
   end

   // Channel totals for the whole controller, this block included
   assign sys_din = 9'(other_din) + 9'(n_din16 * DIN16_CHANNELS);
   assign sys_dout = 9'(other_dout) + 9'(n_dout16 * DOUT16_CHANNELS)
      + 9'(n_dout8 * DOUT8_CHANNELS);
   assign sys_ain = 9'(other_ain) + 9'(n_ain) + 9'(n_ain_fast);
   assign sys_aout = 9'(other_aout) + 9'(n_aout);

   assign block_invalid = bad_type
      || (n_used > MAX_MODULES)
      || (n_din16 > MAX_DIN16) || (n_dout16 > MAX_DOUT16)
      || (n_dout8 > MAX_DOUT8) || (n_ain > MAX_AIN)
      || (n_ain_fast > MAX_AIN_FAST) || (n_aout > MAX_AOUT)
      || ((n_ain + n_ain_fast) > MAX_ANALOG_IN_MIX)
      || (n_aout > MAX_ANALOG_OUT_MIX);

   assign system_invalid = (sys_din > MAX_SYS_DIN) || (sys_dout > MAX_SYS_DOUT)
      || (sys_ain > MAX_SYS_AIN) || (sys_aout > MAX_SYS_AOUT);

endmodule
`default_nettype wire

//--- bench/host_beat_model.sv
// Cyclic sign-of-life source standing in for the host or the controller
`timescale 1ns/1ps
`default_nettype none
module host_beat_model
#(
   parameter int PERIOD = 4
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic alive,
   output logic beat
);
   int count;
   // Stalls while alive is low, so the far side can fall silent
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         count <= 0;
         beat <= 1'b0;
      end
      else if (alive)
      begin
         count <= (count == PERIOD - 1) ? 0 : count + 1;
         if (count == PERIOD - 1)
            beat <= ~beat;
      end
   end
endmodule
`default_nettype wire

//--- bench/terminal_block_supervisor_properties.sv
// Concurrent checks on the supervisor's ports
`timescale 1ns/1ps
`default_nettype none
module supervisor_properties
#(
   parameter int HOST_TIMEOUT = 20,
   parameter int MCU_TIMEOUT = 20
)
(
   input wire logic CLK_SYS,
   input wire logic RESET,
   input wire logic UNDERVOLTAGE,
   input wire logic OVERTEMP,
   input wire logic HOST_BEAT,
   input wire logic MCU_BEAT,
   input wire logic [15:0] DIN16_LEVELS,
   input wire logic OUTPUT_SAFE_DISABLE,
   input wire logic LED_GREEN,
   input wire logic LED_RED,
   input wire logic LED_YELLOW,
   input wire logic [15:0] DIN16_LEDS,
   input wire logic STATUS_OVERTEMP,
   input wire logic STATUS_CONFIG_FAULT,
   input wire logic STATUS_HOST_LOST,
   input wire logic STATUS_MCU_LOST
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (RESET);
   // ----------------
   // Helper counters
   // ----------------
   logic [2:0] up;
   int hq;
   int mq;
   logic hb;
   logic mb;
   logic ok;
   logic fault;
   // Checks wait out the start state and the pin synchronisers
   assign ok = (up >= 3'h5);
   assign fault = STATUS_HOST_LOST | STATUS_MCU_LOST | STATUS_CONFIG_FAULT;
   always_ff @(posedge CLK_SYS)
   begin
      if (RESET)
      begin
         up <= 3'h0;
         hq <= 0;
         mq <= 0;
      end
      else
      begin
         if (up != 3'h7)
            up <= up + 3'h1;
         hq <= (HOST_BEAT != hb) ? 0 : ((hq < 1000) ? hq + 1 : hq);
         mq <= (MCU_BEAT != mb) ? 0 : ((mq < 1000) ? mq + 1 : mq);
      end
      hb <= HOST_BEAT;
      mb <= MCU_BEAT;
   end
   // ----------------
   // Assertions
   // ----------------
   green_supply_a: assert property (ok |-> LED_GREEN == !$past(UNDERVOLTAGE, 3))
      else $error("green indicator wrong");
   supply_disable_a: assert property (ok && $past(UNDERVOLTAGE, 3) |-> OUTPUT_SAFE_DISABLE)
      else $error("no disable on undervoltage");
   overtemp_status_a: assert property (ok |-> STATUS_OVERTEMP == $past(OVERTEMP, 3))
      else $error("overtemperature status wrong");
   overtemp_keeps_a: assert property (ok && $rose(STATUS_OVERTEMP) |-> $stable(OUTPUT_SAFE_DISABLE))
      else $error("overtemperature moved the disable");
   red_cause_a: assert property (ok |-> LED_RED == fault)
      else $error("red indicator wrong");
   yellow_config_a: assert property (ok |-> LED_YELLOW == STATUS_CONFIG_FAULT)
      else $error("yellow indicator wrong");
   fault_disable_a: assert property (ok && fault && $past(fault) |-> OUTPUT_SAFE_DISABLE)
      else $error("fault without disable");
   din_mirror_a: assert property (ok |-> DIN16_LEDS == $past(DIN16_LEVELS, 3))
      else $error("input indicators wrong");
   host_lost_a: assert property (hq >= HOST_TIMEOUT + 6 |-> STATUS_HOST_LOST)
      else $error("silent host not flagged");
   host_alive_a: assert property (hq >= 6 && hq < HOST_TIMEOUT |-> !STATUS_HOST_LOST)
      else $error("live host flagged");
   mcu_lost_a: assert property (mq >= MCU_TIMEOUT + 6 |-> STATUS_MCU_LOST)
      else $error("silent controller not flagged");
   mcu_alive_a: assert property (mq >= 6 && mq < MCU_TIMEOUT |-> !STATUS_MCU_LOST)
      else $error("live controller flagged");
endmodule
bind terminal_block_supervisor supervisor_properties #(.HOST_TIMEOUT(HOST_TIMEOUT),
   .MCU_TIMEOUT(MCU_TIMEOUT)) chk_u (.CLK_SYS(CLK_SYS), .RESET(RESET),
   .UNDERVOLTAGE(UNDERVOLTAGE), .OVERTEMP(OVERTEMP), .HOST_BEAT(HOST_BEAT),
   .MCU_BEAT(MCU_BEAT), .DIN16_LEVELS(DIN16_LEVELS), .OUTPUT_SAFE_DISABLE(OUTPUT_SAFE_DISABLE),
   .LED_GREEN(LED_GREEN), .LED_RED(LED_RED), .LED_YELLOW(LED_YELLOW), .DIN16_LEDS(DIN16_LEDS),
   .STATUS_OVERTEMP(STATUS_OVERTEMP), .STATUS_CONFIG_FAULT(STATUS_CONFIG_FAULT),
   .STATUS_HOST_LOST(STATUS_HOST_LOST), .STATUS_MCU_LOST(STATUS_MCU_LOST));
`default_nettype wire

//--- bench/terminal_block_supervisor_tb.sv
// Self-checking bench for the terminal block supervisor
`timescale 1ns/1ps
`default_nettype none
module terminal_block_supervisor_tb
   import tb_supervisor_pkg::*;
;
   localparam int TO = 20;
   localparam logic [2:0] EM = TYPE_EMPTY, DI = TYPE_DIN16, DQ = TYPE_DOUT16, D8 = TYPE_DOUT8;
   localparam logic [2:0] AI = TYPE_AIN, AF = TYPE_AIN_FAST, AQ = TYPE_AOUT;
   logic CLK_SYS, RESET, UNDERVOLTAGE, OVERTEMP, HOST_BEAT, MCU_BEAT;
   logic [23:0] SLOT_TYPES;
   logic [7:0] OTHER_DIN, OTHER_DOUT, OTHER_AIN, OTHER_AOUT;
   logic [15:0] DIN16_LEVELS, DIN16_LEDS;
   logic [1:0] alive;
   logic OUTPUT_SAFE_DISABLE, LED_GREEN, LED_RED, LED_YELLOW;
   logic STATUS_OVERTEMP, STATUS_CONFIG_FAULT, STATUS_HOST_LOST, STATUS_MCU_LOST;
   int err_count = 0;
   int comparisons = 0;
   int cycles = 0;
   terminal_block_supervisor #(.HOST_TIMEOUT(TO), .MCU_TIMEOUT(TO)) dut_u (.CLK_SYS(CLK_SYS),
      .RESET(RESET), .SLOT_TYPES(SLOT_TYPES), .OTHER_DIN(OTHER_DIN), .OTHER_DOUT(OTHER_DOUT),
      .OTHER_AIN(OTHER_AIN), .OTHER_AOUT(OTHER_AOUT), .UNDERVOLTAGE(UNDERVOLTAGE),
      .OVERTEMP(OVERTEMP), .HOST_BEAT(HOST_BEAT), .MCU_BEAT(MCU_BEAT),
      .DIN16_LEVELS(DIN16_LEVELS), .OUTPUT_SAFE_DISABLE(OUTPUT_SAFE_DISABLE),
      .LED_GREEN(LED_GREEN), .LED_RED(LED_RED), .LED_YELLOW(LED_YELLOW),
      .DIN16_LEDS(DIN16_LEDS), .STATUS_OVERTEMP(STATUS_OVERTEMP),
      .STATUS_CONFIG_FAULT(STATUS_CONFIG_FAULT), .STATUS_HOST_LOST(STATUS_HOST_LOST),
      .STATUS_MCU_LOST(STATUS_MCU_LOST));
   // Host beats fast, controller slower, both well inside the timeout
   host_beat_model #(.PERIOD(4)) host_u (.clk(CLK_SYS), .reset(RESET), .alive(alive[0]),
      .beat(HOST_BEAT));
   host_beat_model #(.PERIOD(7)) mcu_u (.clk(CLK_SYS), .reset(RESET), .alive(alive[1]),
      .beat(MCU_BEAT));
   initial
   begin
      CLK_SYS = 1'b0;
      forever #10 CLK_SYS = ~CLK_SYS;
   end
   always @(posedge CLK_SYS)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         err_count++;
         complete_run();
      end
   end
   // ----------------
   // Tasks
   // ----------------
   task automatic complete_run();
      $display("Comparisons %0d, errors %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge CLK_SYS);
      #1;
   endtask
   function automatic logic [23:0] sl(input logic [2:0] a, b, c, d, e, f, g, h);
      return {h, g, f, e, d, c, b, a};
   endfunction
   task automatic run_cfg(input logic [23:0] s, input logic [31:0] oth, input logic bad);
      @(posedge CLK_SYS);
      SLOT_TYPES <= s;
      {OTHER_DIN, OTHER_DOUT, OTHER_AIN, OTHER_AOUT} <= oth;
      settle(5);
      check("config status", 16'(bad), 16'(STATUS_CONFIG_FAULT));
      check("yellow", 16'(bad), 16'(LED_YELLOW));
      check("red", 16'(bad), 16'(LED_RED));
      check("safe disable", 16'(bad), 16'(OUTPUT_SAFE_DISABLE));
   endtask
   task automatic lose(input int i);
      @(posedge CLK_SYS);
      alive[i] <= 1'b0;
      settle(TO + 8);
      check("lost", 16'h1, 16'(i ? STATUS_MCU_LOST : STATUS_HOST_LOST));
      check("red", 16'h1, 16'(LED_RED));
      check("safe disable", 16'h1, 16'(OUTPUT_SAFE_DISABLE));
      @(posedge CLK_SYS);
      alive[i] <= 1'b1;
      settle(12);
      check("recovered", 16'h0, 16'(OUTPUT_SAFE_DISABLE | LED_RED));
   endtask
   // ----------------
   // Main sequence
   // ----------------
   initial
   begin
      RESET = 1'b1;
      {UNDERVOLTAGE, OVERTEMP, DIN16_LEVELS, SLOT_TYPES} = '0;
      {OTHER_DIN, OTHER_DOUT, OTHER_AIN, OTHER_AOUT} = '0;
      alive = 2'h3;
      settle(3);
      check("disable in reset", 16'h1, 16'(OUTPUT_SAFE_DISABLE));
      @(posedge CLK_SYS);
      RESET <= 1'b0;
      settle(8);
      check("green", 16'h1, 16'(LED_GREEN));
      run_cfg(sl(EM, EM, EM, EM, EM, EM, EM, EM), 32'h0, 1'b0);
      run_cfg(sl(DI, DI, DQ, DQ, EM, EM, EM, EM), 32'h0, 1'b0);
      run_cfg(sl(DI, DI, DI, EM, EM, EM, EM, EM), 32'h0, 1'b1);
      run_cfg(sl(DI, DI, EM, EM, EM, EM, EM, EM), 32'h01000000, 1'b1);
      run_cfg(sl(D8, D8, D8, D8, D8, EM, EM, EM), 32'h0, 1'b1);
      run_cfg(sl(AI, AI, AI, AI, AQ, AQ, AQ, AQ), 32'h0, 1'b0);
      run_cfg(sl(AI, AI, AF, AF, AF, EM, EM, EM), 32'h0, 1'b1);
      run_cfg(sl(AF, AF, AF, AF, AF, EM, EM, EM), 32'h0, 1'b1);
      run_cfg(sl(AQ, AQ, AQ, AQ, AQ, EM, EM, EM), 32'h0, 1'b1);
      run_cfg(sl(AQ, AQ, AQ, AQ, EM, EM, EM, EM), 32'h00000004, 1'b0);
      run_cfg(sl(AI, AI, AI, AI, EM, EM, EM, EM), 32'h00000500, 1'b1);
      run_cfg(sl(3'h7, EM, EM, EM, EM, EM, EM, EM), 32'h0, 1'b1);
      run_cfg(sl(EM, EM, EM, EM, EM, EM, EM, EM), 32'h0, 1'b0);
      @(posedge CLK_SYS);
      UNDERVOLTAGE <= 1'b1;
      settle(5);
      check("undervoltage disable", 16'h1, 16'(OUTPUT_SAFE_DISABLE));
      check("green off", 16'h0, 16'(LED_GREEN));
      @(posedge CLK_SYS);
      UNDERVOLTAGE <= 1'b0;
      settle(5);
      check("supply recovered", 16'h1, 16'(LED_GREEN & ~OUTPUT_SAFE_DISABLE));
      // Overtemperature rises only after the disable has settled low
      @(posedge CLK_SYS);
      OVERTEMP <= 1'b1;
      settle(5);
      check("overtemp status", 16'h1, 16'(STATUS_OVERTEMP));
      check("overtemp no disable", 16'h0, 16'(OUTPUT_SAFE_DISABLE));
      @(posedge CLK_SYS);
      OVERTEMP <= 1'b0;
      DIN16_LEVELS <= 16'ha5c3;
      settle(5);
      check("input indicators", 16'ha5c3, DIN16_LEDS);
      lose(0);
      lose(1);
      complete_run();
   end
endmodule
`default_nettype wire
